// [core/secp_pkg.sv]
// Constants and types of the serial EEPROM command port.
// Assumes a single system clock; every serial pin is sampled by it.
package secp_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned PROG_TIME_MS = 10;
	localparam int unsigned NS_PER_MS = 1_000_000;
	// Longest programming time, rounded down to whole clock cycles.
	localparam int unsigned PROG_CYCLES = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam logic [1:0] OPC_EXT = 2'h0;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_READ = 2'h2;
	localparam logic [1:0] OPC_ERASE = 2'h3;
	localparam logic [1:0] SUB_LOCK = 2'h0;
	localparam logic [1:0] SUB_FILL = 2'h1;
	localparam logic [1:0] SUB_CLEAR = 2'h2;
	localparam logic [1:0] SUB_UNLOCK = 2'h3;
	localparam logic [4:0] OPC_BITS = 5'h02;
	localparam logic [4:0] ABITS_X8 = 5'h07;
	localparam logic [4:0] ABITS_X16 = 5'h06;
	localparam logic [4:0] DBITS_X8 = 5'h08;
	localparam logic [4:0] DBITS_X16 = 5'h10;
	localparam logic [15:0] ERASED = 16'hFFFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int unsigned WORDS = 64;
	localparam int unsigned FIFO_WIDTH = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned SY_CS = 0;
	localparam int unsigned SY_TICK = 1;
	localparam int unsigned SY_DIN = 2;
	localparam int unsigned SY_ORG = 3;
	localparam int unsigned SY_N = 4;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_START = 3'h1,
		S_OPC = 3'h2,
		S_ADDR = 3'h3,
		S_DATA = 3'h4,
		S_READ = 3'h5,
		S_WAIT = 3'h6,
		S_PROG = 3'h7
	} secp_state_t;
	typedef enum logic [1:0] {
		C_WRITE = 2'h0,
		C_ERASE = 2'h1,
		C_CLEAR = 2'h2,
		C_FILL = 2'h3
	} secp_cmd_t;
endpackage : secp_pkg

// [core/secp_port.sv]
// Read-data FIFO and the command port of a 1 Kbit three-wire serial EEPROM.
// Assumes the host pins are asynchronous to clk_sys and much slower than it.

module secp_fifo #(
	parameter int unsigned W = 16,
	parameter int unsigned D = 8
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int unsigned AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [AW:0] cnt, next_cnt;
	logic push, pop;
	assign in_ready = cnt != (AW+1)'(D);
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready && !flush;
	assign pop = out_valid && out_ready && !flush;
	always_comb begin
		next_wp = push ? wp + 1'b1 : wp;
		next_rp = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			next_wp = '0;
			next_rp = '0;
			next_cnt = '0;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
endmodule : secp_fifo

// Summary of operation
// - Select rise, tick low, then start one.
// - Two op-code bits; 00 uses address bits.
// - Seven address bits bytewise, six wordwise.
// - Width select high means words, low bytes.
// - Codes 10 fetch, 01 program, 11 clear.
// - Sub-codes 11 unlock, 00 lock programming.
// - Sub-codes 10 clear all, 01 fill all.
// - Fetch outputs dummy zero, then data MSB-first.
// - Read data output changes only on rising tick.
// - Held select streams following words, no dummy.
// - Read address wraps to zero.
// - Programming cycle is self-timed.
// - Program erases then writes one location.
// - Select must fall before next tick rise.
// - Clear sets location ones on select fall.
// - Clear all sets whole array ones.
// - Busy low, then ready high, data ignored.
// - Power-up leaves programming locked.
// - Unlock holds until lock or power loss.
// - Fetch works whether locked or not.
// - Static inputs; tick may pause anywhere.
// - Fill all does no erase beforehand.
// - Ready stays high until start or deselect.
module secp_port #(
	parameter int unsigned PROG_CYCLES = secp_pkg::PROG_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic chip_enable_in,
	input wire logic shift_tick,
	input wire logic serial_in,
	input wire logic width_select,
	output logic serial_out,
	output logic serial_out_oe
);
	logic [secp_pkg::SY_N-1:0] pins, sy_m, sy_s;
	logic cs_d, tk_d, cs_rise, tk_rise;
	secp_pkg::secp_state_t st, next_st;
	secp_pkg::secp_cmd_t cmd, next_cmd;
	logic [4:0] cnt, next_cnt, left, next_left, abits, dbits;
	logic [1:0] opc, next_opc, lead;
	logic [6:0] addr, next_addr, ptr, next_ptr, sh_addr;
	logic [15:0] dat, next_dat, sh, next_sh, al, rd_word, f_in, f_data;
	logic locked, next_locked, rdy, next_rdy, wide, next_wide;
	logic next_out, next_oe, pop, commit, f_ready, f_valid;
	logic [31:0] pcnt, next_pcnt;
	logic [15:0] mem [secp_pkg::WORDS];

	function automatic logic [5:0] word_idx(input logic [6:0] a, input logic w);
		word_idx = w ? a[5:0] : a[6:1];
	endfunction : word_idx

	// Each host pin passes two flip-flops before any logic reads it.
	assign pins = {width_select, serial_in, shift_tick, chip_enable_in};
	genvar gi;
	generate
		for (gi = 0; gi < secp_pkg::SY_N; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					sy_m[gi] <= 1'b0;
					sy_s[gi] <= 1'b0;
				end else begin
					sy_m[gi] <= pins[gi];
					sy_s[gi] <= sy_m[gi];
				end
			end
		end
	endgenerate
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cs_d <= 1'b0;
			tk_d <= 1'b0;
		end else begin
			cs_d <= sy_s[secp_pkg::SY_CS];
			tk_d <= sy_s[secp_pkg::SY_TICK];
		end
	end
	assign cs_rise = sy_s[secp_pkg::SY_CS] && !cs_d;
	assign tk_rise = sy_s[secp_pkg::SY_TICK] && !tk_d;

	assign abits = wide ? secp_pkg::ABITS_X16 : secp_pkg::ABITS_X8;
	assign dbits = wide ? secp_pkg::DBITS_X16 : secp_pkg::DBITS_X8;
	assign sh_addr = {addr[5:0], sy_s[secp_pkg::SY_DIN]};
	assign lead = wide ? sh_addr[5:4] : sh_addr[6:5];
	assign rd_word = mem[word_idx(ptr, wide)];
	assign f_in = wide ? rd_word : {secp_pkg::BYTE_ZERO, ptr[0] ? rd_word[7:0] : rd_word[15:8]};
	assign al = wide ? f_data : {f_data[7:0], secp_pkg::BYTE_ZERO};

	secp_fifo #(.W(secp_pkg::FIFO_WIDTH), .D(secp_pkg::FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.flush(st != secp_pkg::S_READ),
		.in_valid(st == secp_pkg::S_READ),
		.in_ready(f_ready),
		.in_data(f_in),
		.out_valid(f_valid),
		.out_ready(pop),
		.out_data(f_data)
	);

	always_comb begin
		next_st = st;
		next_cmd = cmd;
		next_cnt = cnt;
		next_opc = opc;
		next_addr = addr;
		next_dat = dat;
		next_locked = locked;
		next_rdy = rdy;
		next_wide = wide;
		next_pcnt = pcnt;
		next_out = serial_out;
		next_oe = serial_out_oe;
		next_sh = sh;
		next_left = left;
		next_ptr = ptr;
		pop = 1'b0;
		commit = 1'b0;
		unique case (st)
			secp_pkg::S_IDLE: begin
				if (cs_rise && !sy_s[secp_pkg::SY_TICK]) begin
					next_st = secp_pkg::S_START;
					next_wide = sy_s[secp_pkg::SY_ORG];
				end
			end
			secp_pkg::S_START: begin
				if (tk_rise && sy_s[secp_pkg::SY_DIN]) begin
					next_st = secp_pkg::S_OPC;
					next_cnt = '0;
					next_rdy = 1'b0;
					next_oe = 1'b0;
				end
			end
			secp_pkg::S_OPC: begin
				if (tk_rise) begin
					next_opc = {opc[0], sy_s[secp_pkg::SY_DIN]};
					next_cnt = cnt + 5'h01;
					if (cnt == secp_pkg::OPC_BITS - 5'h01) begin
						next_st = secp_pkg::S_ADDR;
						next_cnt = '0;
					end
				end
			end
			secp_pkg::S_ADDR: begin
				if (tk_rise) begin
					next_addr = sh_addr;
					next_cnt = cnt + 5'h01;
					if (cnt == abits - 5'h01) begin
						next_cnt = '0;
						next_st = secp_pkg::S_WAIT;
						unique case (opc)
							secp_pkg::OPC_READ: begin
								next_st = secp_pkg::S_READ;
								next_ptr = wide ? {1'b0, sh_addr[5:0]} : sh_addr;
								next_out = 1'b0;
								next_oe = 1'b1;
								next_left = '0;
							end
							secp_pkg::OPC_WRITE: begin
								next_cmd = secp_pkg::C_WRITE;
								next_st = secp_pkg::S_DATA;
							end
							secp_pkg::OPC_ERASE: begin
								next_cmd = secp_pkg::C_ERASE;
							end
							secp_pkg::OPC_EXT: begin
								unique case (lead)
									secp_pkg::SUB_UNLOCK: begin
										next_locked = 1'b0;
										next_st = secp_pkg::S_IDLE;
									end
									secp_pkg::SUB_LOCK: begin
										next_locked = 1'b1;
										next_st = secp_pkg::S_IDLE;
									end
									secp_pkg::SUB_CLEAR: begin
										next_cmd = secp_pkg::C_CLEAR;
									end
									secp_pkg::SUB_FILL: begin
										next_cmd = secp_pkg::C_FILL;
										next_st = secp_pkg::S_DATA;
									end
								endcase
							end
						endcase
					end
				end
			end
			secp_pkg::S_DATA: begin
				if (tk_rise) begin
					next_dat = {dat[14:0], sy_s[secp_pkg::SY_DIN]};
					next_cnt = cnt + 5'h01;
					if (cnt == dbits - 5'h01) begin
						next_st = secp_pkg::S_WAIT;
					end
				end
			end
			secp_pkg::S_WAIT: begin
				// A further tick rise before deselect cancels the instruction.
				if (tk_rise) begin
					next_st = secp_pkg::S_IDLE;
				end
			end
			secp_pkg::S_READ: begin
				if (f_ready) begin
					next_ptr = wide ? {1'b0, ptr[5:0] + 6'h01} : ptr + 7'h01;
				end
				if (tk_rise) begin
					if (left == '0) begin
						if (f_valid) begin
							pop = 1'b1;
							next_out = al[15];
							next_sh = {al[14:0], 1'b0};
							next_left = dbits - 5'h01;
						end
					end else begin
						next_out = sh[15];
						next_sh = {sh[14:0], 1'b0};
						next_left = left - 5'h01;
					end
				end
			end
			secp_pkg::S_PROG: begin
				// Runs on clk_sys alone, whatever the tick and data pins do.
				next_pcnt = pcnt + 32'h1;
				next_out = 1'b0;
				next_oe = sy_s[secp_pkg::SY_CS];
				if (pcnt == PROG_CYCLES - 1) begin
					commit = 1'b1;
					next_out = 1'b1;
					next_rdy = sy_s[secp_pkg::SY_CS];
					next_st = sy_s[secp_pkg::SY_CS] ? secp_pkg::S_START : secp_pkg::S_IDLE;
				end
			end
		endcase
		if (!sy_s[secp_pkg::SY_CS] && st != secp_pkg::S_PROG) begin
			next_oe = 1'b0;
			next_rdy = 1'b0;
			next_st = secp_pkg::S_IDLE;
			if (st == secp_pkg::S_WAIT && !locked) begin
				next_st = secp_pkg::S_PROG;
				next_pcnt = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= secp_pkg::S_IDLE;
			cmd <= secp_pkg::C_WRITE;
			cnt <= '0;
			opc <= '0;
			addr <= '0;
			dat <= '0;
			locked <= 1'b1;
			rdy <= 1'b0;
			wide <= 1'b0;
			pcnt <= '0;
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
			sh <= '0;
			left <= '0;
			ptr <= '0;
		end else begin
			st <= next_st;
			cmd <= next_cmd;
			cnt <= next_cnt;
			opc <= next_opc;
			addr <= next_addr;
			dat <= next_dat;
			locked <= next_locked;
			rdy <= next_rdy;
			wide <= next_wide;
			pcnt <= next_pcnt;
			serial_out <= next_out;
			serial_out_oe <= next_oe;
			sh <= next_sh;
			left <= next_left;
			ptr <= next_ptr;
		end
	end

	// The array starts erased; a byte write touches only its own lane.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < secp_pkg::WORDS; i++) begin
				mem[i] <= secp_pkg::ERASED;
			end
		end else if (commit) begin
			unique case (cmd)
				secp_pkg::C_WRITE: begin
					if (wide) begin
						mem[word_idx(addr, wide)] <= dat;
					end else if (addr[0]) begin
						mem[word_idx(addr, wide)][7:0] <= dat[7:0];
					end else begin
						mem[word_idx(addr, wide)][15:8] <= dat[7:0];
					end
				end
				secp_pkg::C_ERASE: begin
					if (wide) begin
						mem[word_idx(addr, wide)] <= secp_pkg::ERASED;
					end else if (addr[0]) begin
						mem[word_idx(addr, wide)][7:0] <= secp_pkg::ERASED[7:0];
					end else begin
						mem[word_idx(addr, wide)][15:8] <= secp_pkg::ERASED[7:0];
					end
				end
				secp_pkg::C_CLEAR: begin
					for (int i = 0; i < secp_pkg::WORDS; i++) begin
						mem[i] <= secp_pkg::ERASED;
					end
				end
				secp_pkg::C_FILL: begin
					for (int i = 0; i < secp_pkg::WORDS; i++) begin
						mem[i] <= mem[i] & (wide ? dat : {dat[7:0], dat[7:0]});
					end
				end
			endcase
		end
	end

	a_start_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_START && sy_s[secp_pkg::SY_CS] && tk_rise && !sy_s[secp_pkg::SY_DIN])
		|=> st == secp_pkg::S_START) else $error("start left without a one bit");
	a_dummy_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_ADDR && next_st == secp_pkg::S_READ) |=> (!serial_out && serial_out_oe))
		else $error("no dummy zero before read data");
	a_out_on_tick: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_READ && $past(st == secp_pkg::S_READ) && $changed(serial_out)) |-> $past(tk_rise))
		else $error("read data changed without a tick rise");
	a_addr_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_READ && f_ready && ptr == (wide ? 7'h3F : 7'h7F)) |=> ptr == 7'h00)
		else $error("read address did not wrap");
	a_prog_timed: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(st == secp_pkg::S_PROG) |-> (st == secp_pkg::S_PROG)[*8])
		else $error("programming cycle ended early");
	a_busy_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_PROG && $past(st == secp_pkg::S_PROG) && sy_s[secp_pkg::SY_CS] && commit == 1'b0)
		|=> (!serial_out && serial_out_oe)) else $error("busy not shown during programming");
	a_ready_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(commit && sy_s[secp_pkg::SY_CS]) |=> (serial_out && serial_out_oe)[*2] or
		(serial_out && serial_out_oe ##1 !sy_s[secp_pkg::SY_CS]))
		else $error("ready not held high");
	a_locked_guard: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(st == secp_pkg::S_WAIT && locked) |=> st != secp_pkg::S_PROG)
		else $error("locked device started programming");
	a_oe_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!sy_s[secp_pkg::SY_CS] && st != secp_pkg::S_PROG) |=> !serial_out_oe)
		else $error("output driven while deselected");
	c_read: cover property (@(posedge clk_sys) disable iff (!rst_b) pop);
	c_program: cover property (@(posedge clk_sys) disable iff (!rst_b) commit && cmd == secp_pkg::C_WRITE);
	c_clear_all: cover property (@(posedge clk_sys) disable iff (!rst_b) commit && cmd == secp_pkg::C_CLEAR);
	c_unlock: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(locked));
endmodule : secp_port

// [verif/secp_host.sv]
// Host model that drives select, serial clock and data of the command port.
// Assumes serial_out and serial_out_oe come straight from the device and no pull sits on the pin.
module secp_host (
	output logic chip_enable_in,
	output logic shift_tick,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	output logic q_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic q_last = 1'b0;
	// A released pin shows the inverse of its last driven level.
	always @(serial_out or serial_out_oe) begin
		if (serial_out_oe) begin
			q_last = serial_out;
		end
	end
	assign q_pin = serial_out_oe ? serial_out : ~q_last;
	initial begin
		chip_enable_in = 1'b0;
		shift_tick = 1'b0;
		serial_in = 1'b0;
	end
	task automatic sel_up();
		shift_tick = 1'b0;
		chip_enable_in = 1'b1;
		#62.5;
	endtask : sel_up
	task automatic sel_down(input int low_ns);
		chip_enable_in = 1'b0;
		serial_in = ~serial_in;
		#(low_ns);
	endtask : sel_down
	// One clock per element; each sample is taken just before the clock falls.
	task automatic shift(input logic din[$], output logic dq[$]);
		dq = {};
		foreach (din[i]) begin
			serial_in = din[i];
			#62.5;
			shift_tick = 1'b1;
			#62.5;
			dq.push_back(q_pin);
			shift_tick = 1'b0;
		end
	endtask : shift
endmodule : secp_host

// [verif/tb.sv]
// Self-checking bench of the command port with a word-array reference model.
// Assumes the host model drives the serial pins and clk_sys runs at 125 MHz.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PROG = 200;
	logic clk_sys, rst_b, width_select, chip_enable_in, shift_tick, serial_in, serial_out, serial_out_oe, q_pin;
	logic [15:0] mem [64];
	bit unlocked = 1'b0;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	secp_port #(.PROG_CYCLES(PROG)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .chip_enable_in(chip_enable_in),
		.shift_tick(shift_tick), .serial_in(serial_in), .width_select(width_select), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe));
	secp_host host_u (.chip_enable_in(chip_enable_in), .shift_tick(shift_tick), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .q_pin(q_pin));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			print_verdict();
		end
	end
	function automatic int ab();
		return width_select ? 6 : 7;
	endfunction : ab
	function automatic int db();
		return width_select ? 16 : 8;
	endfunction : db
	function automatic logic [15:0] exp_at(input int a);
		if (width_select) begin
			return mem[a];
		end
		return a[0] ? {8'h00, mem[a >> 1][7:0]} : {8'h00, mem[a >> 1][15:8]};
	endfunction : exp_at
	function automatic void add(ref logic q[$], input int n, input int v);
		for (int i = n - 1; i >= 0; i--) begin
			q.push_back(v[i]);
		end
	endfunction : add
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic xfer(input int op, input int addr, input int dat, input int nq, output logic dq[$]);
		logic din[$];
		add(din, 3, 4 | op);
		add(din, ab(), addr);
		if (op == 1 || (op == 0 && (addr >> (ab() - 2)) == 1)) begin
			add(din, db(), dat);
		end
		repeat (nq) din.push_back(1'b0);
		host_u.sel_up();
		host_u.shift(din, dq);
	endtask : xfer
	task automatic cfg(input int s);
		logic dq[$];
		xfer(0, s << (ab() - 2), 0, 0, dq);
		host_u.sel_down(250);
		unlocked = (s == 3) ? 1'b1 : (s == 0) ? 1'b0 : unlocked;
	endtask : cfg
	task automatic prog(input int op, input int addr, input int dat);
		logic dq[$];
		int n;
		int w;
		int sub;
		xfer(op, addr, dat, 0, dq);
		w = width_select ? addr : addr >> 1;
		sub = addr >> (ab() - 2);
		if (!unlocked) begin
			host_u.sel_down(250);
			return;
		end
		host_u.sel_down(40);
		host_u.sel_up();
		cmp(q_pin, 1'b0);
		n = 0;
		while (q_pin !== 1'b1 && n < 2 * PROG) begin
			#8;
			n++;
		end
		cmp(n > PROG / 2 && n < 2 * PROG, 1'b1);
		#200;
		cmp(q_pin, 1'b1);
		host_u.sel_down(250);
		if (op == 1 && width_select) mem[w] = dat[15:0];
		if (op == 1 && !width_select) mem[w] = addr[0] ? {mem[w][15:8], dat[7:0]} : {dat[7:0], mem[w][7:0]};
		if (op == 3 && width_select) mem[w] = 16'hFFFF;
		if (op == 3 && !width_select) mem[w] = addr[0] ? {mem[w][15:8], 8'hFF} : {8'hFF, mem[w][7:0]};
		for (int i = 0; i < 64; i++) begin
			if (op == 0 && sub == 2) mem[i] = 16'hFFFF;
			if (op == 0 && sub == 1) mem[i] &= width_select ? dat[15:0] : {dat[7:0], dat[7:0]};
		end
	endtask : prog
	task automatic rd(input int addr, input int nw);
		logic dq[$];
		logic [15:0] got;
		int a;
		xfer(2, addr, 0, nw * db(), dq);
		repeat (2 + ab()) void'(dq.pop_front());
		cmp(dq.pop_front(), 16'h0000);
		a = addr;
		repeat (nw) begin
			got = 16'h0000;
			repeat (db()) got = {got[14:0], dq.pop_front()};
			cmp(got, exp_at(a));
			a = (a + 1) % (width_select ? 64 : 128);
		end
		host_u.sel_down(250);
		cmp(serial_out_oe, 1'b0);
	endtask : rd
	task automatic print_verdict();
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	initial begin
		int a;
		rst_b = 1'b0;
		width_select = 1'b1;
		foreach (mem[i]) mem[i] = 16'hFFFF;
		void'($urandom(32'hE15E));
		repeat (6) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(0, 1);
		prog(1, 5, $urandom);
		rd(5, 1);
		cfg(3);
		repeat (3) begin
			a = $urandom % 64;
			prog(1, a, $urandom);
			rd(a, 1);
		end
		prog(1, 63, $urandom);
		rd(63, 2);
		prog(3, 63, 0);
		rd(62, 2);
		@(negedge clk_sys);
		width_select = 1'b0;
		prog(1, 7, $urandom % 256);
		prog(1, 127, $urandom % 256);
		rd(126, 3);
		prog(3, 6, 0);
		rd(6, 2);
		@(negedge clk_sys);
		width_select = 1'b1;
		prog(0, 2 << 4, 0);
		prog(0, 1 << 4, $urandom);
		prog(0, 1 << 4, $urandom);
		rd($urandom % 64, 2);
		cfg(0);
		prog(1, 9, $urandom);
		rd(9, 1);
		// Ten words in one stream run the read buffer past its depth.
		rd(0, 10);
		rd(60, 9);
		print_verdict();
	end
endmodule : tb
